// ===== verif/core_model.sv
`timescale 1ns/10ps
// stand-in for the core's sleep and clear instructions and the watchdog's own oscillator
module core_model (
  // clock
  input wire logic hclk,
  // instruction side
  output logic sleep_instr,
  output logic watchdog_clear_instr,
  output swc_pkg::prog_addr_t core_pc,
  // watchdog oscillator
  output logic wdog_osc_clk
);
  initial begin
    sleep_instr = 1'b0;
    watchdog_clear_instr = 1'b0;
    core_pc = 13'h0000;
    wdog_osc_clk = 1'b0;
  end

  // free running and unrelated to hclk, so it keeps going while the core sleeps
  always #65 wdog_osc_clk = ~wdog_osc_clk;

  // one-cycle sleep; firmware keeps a no-op at pc+1 so a wake never runs stray code
  task automatic exec_sleep(input swc_pkg::prog_addr_t pc);
    @(posedge hclk);
    sleep_instr <= 1'b1;
    core_pc <= pc;
    @(posedge hclk);
    sleep_instr <= 1'b0;
    core_pc <= ~pc; // address is only valid with the pulse
  endtask

  // one-cycle clear-watchdog instruction
  task automatic exec_clear();
    @(posedge hclk);
    watchdog_clear_instr <= 1'b1;
    @(posedge hclk);
    watchdog_clear_instr <= 1'b0;
  endtask
endmodule // core_model

// ===== verif/test_sleep_wake_controller.sv
`timescale 1ns/10ps
`include "swc_cfg.svh"

module test_sleep_wake_controller;
  localparam logic [31:0] a_opt = {14'h0000, `SWC_OPTION_IDX, 2'b00};
  localparam logic [31:0] a_cfg = {14'h0000, `SWC_CONFIG_IDX, 2'b00};
  localparam logic [31:0] a_stat = {14'h0000, `SWC_STATUS_IDX, 2'b00};
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, irq_flags, irq_enables;
  logic sleep_instr, watchdog_clear_instr, global_irq_enable, master_clear_pin_n, wdog_osc_clk;
  logic [7:0] config_word_pins;
  logic instr_strobe, core_halt, core_resume, irq_branch, osc_drive_en, io_hold;
  logic dev_reset, reset_from_pin, power_down_flag, timeout_flag;
  swc_pkg::prog_addr_t core_pc, irq_vector, prefetch_pc;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int resets_seen = 0;

  sleep_wake_controller #(.NUM_IRQ(3), .WDOG_BASE_TICKS(20)) i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hrdata, .hresp, .sleep_instr, .watchdog_clear_instr, .global_irq_enable,
    .core_pc, .irq_flags, .irq_enables, .instr_strobe, .core_halt, .core_resume, .irq_branch,
    .irq_vector, .prefetch_pc, .master_clear_pin_n, .wdog_osc_clk, .config_word_pins,
    .osc_drive_en, .io_hold, .dev_reset, .reset_from_pin, .power_down_flag, .timeout_flag
  );
  core_model i_core (.hclk, .sleep_instr, .watchdog_clear_instr, .core_pc, .wdog_osc_clk);

  always #12.5 hclk = ~hclk;

  // cycle ceiling cuts a hang short; also counts every cycle in which the design holds dev_reset high
  always @(posedge hclk) begin
    cycles++;
    if (dev_reset === 1'b1) resets_seen++;
    if (cycles == 20000) begin
      num_errors++;
      $display("run exceeded its cycle ceiling");
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // one single ahb-lite transfer; the address phase is held until hready is seen high
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0; // deselected between transfers
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    check(what, exp, r);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic do_reset(input logic [7:0] cfg);
    @(posedge hclk);
    hresetn <= 1'b0;
    config_word_pins <= cfg;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask

  // waits for the resume pulse, counting start-up cycles (oscillator on, pins still held)
  task automatic wait_wake(input int exp_start);
    int n;
    int k;
    int r0;
    n = 0;
    k = 0;
    r0 = resets_seen;
    // count the present cycle first: a pending flag may already have started the wait
    while (core_resume !== 1'b1 && k < 3000) begin
      if (osc_drive_en === 1'b1 && io_hold === 1'b1) n++;
      @(posedge hclk);
      #1;
      k++;
    end
    check("core_resume", 32'h1, {31'h0, core_resume});
    check("startup cycles", exp_start, n);
    check("resets during wake", 0, resets_seen - r0);
  endtask

  task automatic t_reset();
    check("power_down_flag", 1, {31'h0, power_down_flag});
    check("timeout_flag", 1, {31'h0, timeout_flag});
    check("osc_drive_en", 1, {31'h0, osc_drive_en});
    rd_chk("option reset", a_opt, {24'h0, `OPTION_RESET});
    rd_chk("config", a_cfg, 32'h0000_002f);
    rd_chk("status reset", a_stat, 32'h0000_0003);
    rd_chk("unmapped", 32'h0000_0100, 32'h0000_0000);
    wr(a_cfg, 32'h0000_0000); // read-only place, write must be dropped
    rd_chk("config after write", a_cfg, 32'h0000_002f);
    wr(a_opt, 32'h0000_005a);
    rd_chk("option write", a_opt, 32'h0000_005a);
    wr(a_opt, 32'h0000_00ff);
  endtask

  task automatic t_strobe();
    int n;
    n = 0;
    repeat (40) begin
      @(posedge hclk);
      #1;
      if (instr_strobe === 1'b1) n++;
    end
    check("strobes in 40 cycles", 10, n);
  endtask

  // flag on an unenabled source must not wake; enabling it must, whatever the global enable
  task automatic t_sleep_irq(input int src, input logic g);
    @(posedge hclk);
    global_irq_enable <= g;
    irq_enables <= 3'b111 & ~(3'b001 << src);
    i_core.exec_sleep(13'h0100 + 13'(src));
    tick(1);
    check("pd after sleep", 0, {31'h0, power_down_flag});
    check("to after sleep", 1, {31'h0, timeout_flag});
    check("osc off", 0, {31'h0, osc_drive_en});
    check("io hold", 1, {31'h0, io_hold});
    check("prefetch", 13'h0101 + 13'(src), {19'h0, prefetch_pc});
    rd_chk("status asleep", a_stat, 32'h0000_0005);
    @(posedge hclk);
    irq_flags <= 3'b001 << src;
    tick(40);
    check("still asleep", 1, {31'h0, core_halt});
    @(posedge hclk);
    irq_enables <= 3'b001 << src;
    wait_wake(40);
    tick(1);
    check("irq branch", {31'h0, g}, {31'h0, irq_branch});
    check("running", 0, {31'h0, core_halt});
    check("vector", 32'h0000_0004, {19'h0, irq_vector});
    @(posedge hclk);
    irq_flags <= 3'b000;
    irq_enables <= 3'b000;
  endtask

  task automatic t_pending();
    @(posedge hclk);
    global_irq_enable <= 1'b0;
    irq_flags <= 3'b100;
    irq_enables <= 3'b100;
    i_core.exec_sleep(13'h0200);
    tick(1);
    check("pending sleep completes", 0, {31'h0, power_down_flag});
    wait_wake(40);
    @(posedge hclk);
    irq_flags <= 3'b000;
    irq_enables <= 3'b000;
  endtask

  task automatic t_wdog();
    int r0;
    int k;
    wr(a_opt, 32'h0000_0000); // prescaler off: 20 ticks to time-out
    r0 = resets_seen;
    repeat (10) begin
      i_core.exec_clear();
      tick(40);
    end
    check("no reset while cleared", 0, resets_seen - r0);
    check("to after clear", 1, {31'h0, timeout_flag});
    i_core.exec_sleep(13'h0300);
    wait_wake(40);
    check("to after wdog wake", 0, {31'h0, timeout_flag});
    tick(1);
    check("no branch on wdog wake", 0, {31'h0, irq_branch});
    tick(30);
    check("wdog cleared on wake", 0, resets_seen - r0);
    k = 0;
    while (dev_reset !== 1'b1 && k < 600) begin
      tick(1);
      k++;
    end
    check("run timeout resets", 1, {31'h0, dev_reset});
    check("reset not from pin", 0, {31'h0, reset_from_pin});
    tick(1);
    check("reset one cycle", 0, {31'h0, dev_reset});
    check("to after timeout", 0, {31'h0, timeout_flag});
    rd_chk("option after reset", a_opt, 32'h0000_00ff);
  endtask

  task automatic t_pin();
    wr(a_opt, 32'h0000_0033);
    i_core.exec_sleep(13'h0400);
    tick(2);
    @(posedge hclk);
    master_clear_pin_n <= 1'b0;
    tick(6);
    check("pin reset", 1, {31'h0, dev_reset});
    check("pin cause", 1, {31'h0, reset_from_pin});
    check("no resume", 0, {31'h0, core_resume});
    @(posedge hclk);
    master_clear_pin_n <= 1'b1;
    tick(6);
    check("pin reset released", 0, {31'h0, dev_reset});
    check("run after pin", 0, {31'h0, core_halt});
    check("pd kept", 0, {31'h0, power_down_flag});
    rd_chk("option after pin", a_opt, 32'h0000_00ff);
  endtask

  task automatic t_xtal();
    do_reset(8'h28);
    @(posedge hclk);
    global_irq_enable <= 1'b1;
    irq_flags <= 3'b001;
    irq_enables <= 3'b001;
    i_core.exec_sleep(13'h0500);
    wait_wake(1024);
    tick(1);
    check("xtal branch", 1, {31'h0, irq_branch});
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'b00;
    hsize = 3'h2;
    irq_flags = 3'b000;
    irq_enables = 3'b000;
    global_irq_enable = 1'b0;
    master_clear_pin_n = 1'b1;
    config_word_pins = 8'h2f; // pin reset on, watchdog on, rc oscillator
    do_reset(8'h2f);
    t_reset();
    t_strobe();
    for (int s = 0; s < 3; s++) t_sleep_irq(s, s[0]);
    t_pending();
    t_wdog();
    t_pin();
    t_xtal();
    tally_and_finish();
  end
endmodule // test_sleep_wake_controller

// ===== verilog/sleep_wake_controller.sv
`timescale 1ns/10ps
`include "swc_cfg.svh"

// Functional notes
// - sleep clears watchdog, clears power-down flag, sets timeout flag, stops oscillator, holds pins
// - watchdog reset is internal only; master clear pin is never driven
// - sleep ends on master clear, watchdog timeout, or enabled interrupt
// - master clear wake resets all but the status flags; watchdog and interrupt wakes resume execution
// - power-down flag set at power-up, cleared by each sleep instruction
// - watchdog timeout ending sleep clears the timeout flag
// - during sleep the instruction at the next address is prefetched
// - enabled interrupt wakes regardless of global interrupt enable
// - after interrupt wake, run prefetched instruction, then vector if global enable set
// - an already pending enabled interrupt wakes at once after sleep completes
// - watchdog counter cleared on every wake from sleep
// - crystal wake waits 1024 oscillator periods, RC wake about 1 us
// - one instruction cycle is four oscillator periods
// - watchdog timeout resets when running, wakes when asleep
// - clear-watchdog and sleep clear counter and assigned prescaler
// - watchdog on own oscillator, base period 18 ms, prescaler up to 1:128
module sleep_wake_controller #(
  parameter int NUM_IRQ = 3,
  parameter int WDOG_BASE_TICKS = `WDOG_BASE_US / `WDOG_TICK_US
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // processor core
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  input wire logic global_irq_enable,
  input wire swc_pkg::prog_addr_t core_pc,
  input wire logic [NUM_IRQ-1:0] irq_flags,
  input wire logic [NUM_IRQ-1:0] irq_enables,
  output logic instr_strobe,
  output logic core_halt,
  output logic core_resume,
  output logic irq_branch,
  output swc_pkg::prog_addr_t irq_vector,
  output swc_pkg::prog_addr_t prefetch_pc,
  // pins and straps
  input wire logic master_clear_pin_n,
  input wire logic wdog_osc_clk,
  input wire logic [7:0] config_word_pins,
  // power control and status
  output logic osc_drive_en,
  output logic io_hold,
  output logic dev_reset,
  output logic reset_from_pin,
  output logic power_down_flag,
  output logic timeout_flag
);
  localparam logic [15:0] OPT_ADDR = 16'(`SWC_OPTION_IDX << 2);
  localparam logic [15:0] CFG_ADDR = 16'(`SWC_CONFIG_IDX << 2);
  localparam logic [15:0] STAT_ADDR = 16'(`SWC_STATUS_IDX << 2);
  localparam int RC_START_CYC = (`RC_START_NS + `OSC_PERIOD_NS - 1) / `OSC_PERIOD_NS;
  localparam int XTAL_START_CYC = `XTAL_START_TOSC;
  localparam logic [10:0] XTAL_LOAD = 11'(XTAL_START_CYC - 1);
  localparam logic [10:0] RC_LOAD = 11'(RC_START_CYC - 1);

  swc_pkg::pwr_state_e state;
  logic [7:0] timer_option_config;
  logic [7:0] device_config_word;
  logic [1:0] cfg_settle;
  logic [9:0] pin_sync;
  logic master_clear_low;
  logic wdog_tick_lvl;
  logic wdog_tick_last;
  logic master_clear_act;
  logic [1:0] qphase;
  logic [10:0] start_cnt;
  logic wdog_wake_evt;
  logic wake_by_wdog;
  logic wake_by_irq;
  logic irq_pending;
  logic wake_req;
  logic sample;
  logic sleep_take;
  logic wdog_run_reset;
  logic wake_take;
  logic ap_take;
  logic wr_pend;
  logic [15:0] wr_addr;
  logic [7:0] opt_view;
  wdog_if wd ();

  // straps, master clear and watchdog oscillator are foreign; two flops first
  sync2 #(.W(10)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({config_word_pins, master_clear_pin_n, wdog_osc_clk}),
    .q(pin_sync)
  );
  assign master_clear_low = !pin_sync[1];
  assign wdog_tick_lvl = pin_sync[0];

  // pin is only sampled here; no driver exists for it, so a watchdog reset stays inside
  assign master_clear_act = master_clear_low && device_config_word[`CFG_MASTER_CLEAR_EN_BIT];

  // edge of the watchdog oscillator, read from the synchronised copy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdog_tick_last <= 1'b0;
    end else begin
      wdog_tick_last <= wdog_tick_lvl;
    end
  end

  // straps caught once the synchroniser has filled after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_settle <= 2'd0;
      device_config_word <= 8'h00;
    end else if (cfg_settle != 2'd3) begin
      cfg_settle <= cfg_settle + 2'd1;
      device_config_word <= pin_sync[9:2];
    end
  end

  // oscillator phase: four periods make one instruction cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qphase <= 2'd0;
    end else begin
      qphase <= qphase + 2'd1;
    end
  end
  assign sample = (qphase == 2'(`INSTR_TOSC - 1));
  assign instr_strobe = sample && (state == swc_pkg::ST_RUN);

  // wake request: any enabled flag, whatever the global enable, plus watchdog event
  assign irq_pending = |(irq_flags & irq_enables);
  assign wake_req = irq_pending || wdog_wake_evt;
  assign sleep_take = (state == swc_pkg::ST_RUN) && sleep_instr && !master_clear_act;
  assign wake_take = (state == swc_pkg::ST_SLEEP) && sample && wake_req && !master_clear_act;
  assign wdog_run_reset = (state != swc_pkg::ST_SLEEP) && wd.timeout;

  // watchdog wiring; every wake and both instructions clear it
  assign wd.clear = sleep_take || (watchdog_clear_instr && state == swc_pkg::ST_RUN) || wake_take
    || dev_reset;
  assign wd.enable = device_config_word[`CFG_WDOG_EN_BIT];
  assign wd.ps_assign = timer_option_config[`OPT_PRESCALER_ASSIGN_BIT];
  assign wd.ps_rate = timer_option_config[`OPT_RATE_LSB +: 3];
  assign wd.tick = wdog_tick_lvl && !wdog_tick_last;

  wdog_timer #(.BASE_TICKS(WDOG_BASE_TICKS)) u_wdog (
    .hclk(hclk),
    .hresetn(hresetn),
    .w(wd.wdog)
  );

  // a timeout in sleep may fall between samples, so hold it until taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdog_wake_evt <= 1'b0;
    end else if (state == swc_pkg::ST_SLEEP && wd.timeout) begin
      wdog_wake_evt <= 1'b1;
    end else if (wake_take || state != swc_pkg::ST_SLEEP) begin
      wdog_wake_evt <= 1'b0;
    end
  end

  // power sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= swc_pkg::ST_RUN;
      start_cnt <= 11'd0;
      wake_by_wdog <= 1'b0;
      wake_by_irq <= 1'b0;
    end else if (master_clear_act) begin
      state <= swc_pkg::ST_RUN;
    end else begin
      case (state)
        swc_pkg::ST_RUN: begin
          if (sleep_take) begin
            state <= swc_pkg::ST_SLEEP;
          end
        end
        swc_pkg::ST_SLEEP: begin
          // a flag already pending makes the first sample wake straight away
          if (wake_take) begin
            state <= swc_pkg::ST_START;
            wake_by_wdog <= wdog_wake_evt;
            wake_by_irq <= irq_pending;
            start_cnt <= (device_config_word[`CFG_OSC_SEL_LSB +: 3] <= `OSC_XTAL_MAX) ? XTAL_LOAD : RC_LOAD;
          end
        end
        swc_pkg::ST_START: begin
          if (start_cnt == 11'd0) begin
            state <= swc_pkg::ST_RESUME;
          end else begin
            start_cnt <= start_cnt - 11'd1;
          end
        end
        swc_pkg::ST_RESUME: begin
          state <= swc_pkg::ST_RUN;
        end
        default: begin
          state <= swc_pkg::ST_RUN;
        end
      endcase
    end
  end

  // oscillator off and pins frozen until the oscillator is up again
  assign osc_drive_en = (state != swc_pkg::ST_SLEEP);
  assign io_hold = (state == swc_pkg::ST_SLEEP) || (state == swc_pkg::ST_START);
  assign core_halt = (state != swc_pkg::ST_RUN);
  assign core_resume = (state == swc_pkg::ST_RESUME);
  assign irq_vector = `IRQ_VECTOR;

  // resume: prefetched instruction first, then the vector only with global enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_branch <= 1'b0;
    end else begin
      irq_branch <= (state == swc_pkg::ST_RESUME) && wake_by_irq && global_irq_enable;
    end
  end

  // next address is latched as the sleep instruction runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prefetch_pc <= '0;
    end else if (sleep_take) begin
      prefetch_pc <= core_pc + 13'd1;
    end
  end

  // device reset: pin held low, or watchdog timeout while not asleep
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dev_reset <= 1'b0;
      reset_from_pin <= 1'b0;
    end else begin
      dev_reset <= master_clear_act || wdog_run_reset;
      reset_from_pin <= master_clear_act;
    end
  end

  // status flags survive a pin reset so software can tell the cause
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_down_flag <= 1'b1;
      timeout_flag <= 1'b1;
    end else if (sleep_take) begin
      power_down_flag <= 1'b0;
      timeout_flag <= 1'b1;
    end else if (watchdog_clear_instr && state == swc_pkg::ST_RUN) begin
      power_down_flag <= 1'b1;
      timeout_flag <= 1'b1;
    end else if (wd.timeout) begin
      timeout_flag <= 1'b0;
    end
  end

  // ahb-lite slave: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ap_take = hsel && htrans[1] && hready;

  // address phase captured for the write data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 16'h0000;
    end else begin
      wr_pend <= ap_take && hwrite;
      wr_addr <= haddr[15:0];
    end
  end

  // option register; a device reset returns it to all ones
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_option_config <= `OPTION_RESET;
    end else if (dev_reset) begin
      timer_option_config <= `OPTION_RESET;
    end else if (wr_pend && wr_addr == OPT_ADDR) begin
      timer_option_config <= hwdata[7:0];
    end
  end

  // a read right after a write to the same word sees the new value
  assign opt_view = (wr_pend && wr_addr == OPT_ADDR) ? hwdata[7:0] : timer_option_config;

  // read data registered at the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (ap_take && !hwrite) begin
      hrdata <= 32'h00000000;
      if (haddr[31:16] == 16'h0000) begin
        case (haddr[15:0])
          OPT_ADDR: hrdata[7:0] <= opt_view;
          CFG_ADDR: hrdata[7:0] <= device_config_word;
          STAT_ADDR: begin
            hrdata[`STAT_TIMEOUT_BIT] <= timeout_flag;
            hrdata[`STAT_POWER_DOWN_BIT] <= power_down_flag;
            hrdata[`STAT_ASLEEP_BIT] <= (state == swc_pkg::ST_SLEEP);
            hrdata[`STAT_WAKE_PEND_BIT] <= wake_req;
            hrdata[`STAT_STARTUP_BIT] <= (state == swc_pkg::ST_START);
          end
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // cycles spent in start-up, checked on exit
  logic [10:0] start_seen;
  logic start_xtal;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_seen <= 11'd0;
      start_xtal <= 1'b0;
    end else if (wake_take) begin
      start_seen <= 11'd0;
      start_xtal <= (device_config_word[`CFG_OSC_SEL_LSB +: 3] <= `OSC_XTAL_MAX);
    end else if (state == swc_pkg::ST_START) begin
      start_seen <= start_seen + 11'd1;
    end
  end

  AST_SLEEP_ENTRY: assert property (@(posedge hclk) disable iff (!hresetn)
    sleep_take |=> !power_down_flag && timeout_flag && !osc_drive_en && io_hold)
    else $error("sleep entry effects missing");
  AST_PIN_NOT_RESET_BY_WDOG: assert property (@(posedge hclk) disable iff (!hresetn)
    wdog_run_reset && !master_clear_act |=> dev_reset && !reset_from_pin)
    else $error("watchdog reset marked as pin reset");
  AST_IRQ_WAKE: assert property (@(posedge hclk) disable iff (!hresetn)
    state == swc_pkg::ST_SLEEP && sample && irq_pending && !master_clear_act |=> state == swc_pkg::ST_START)
    else $error("enabled interrupt did not wake");
  AST_PIN_WAKE_RESETS: assert property (@(posedge hclk) disable iff (!hresetn)
    state == swc_pkg::ST_SLEEP && master_clear_act |=> dev_reset && state == swc_pkg::ST_RUN)
    else $error("pin wake without reset");
  AST_NO_RESET_ON_RESUME: assert property (@(posedge hclk) disable iff (!hresetn)
    core_resume |-> !dev_reset && $past(state == swc_pkg::ST_START))
    else $error("resume came with reset");
  AST_WDOG_WAKE_CLEARS: assert property (@(posedge hclk) disable iff (!hresetn)
    state == swc_pkg::ST_SLEEP && wd.timeout && !master_clear_act |=> !timeout_flag ##[1:4] state == swc_pkg::ST_START)
    else $error("watchdog wake flag or timing wrong");
  AST_PREFETCH: assert property (@(posedge hclk) disable iff (!hresetn)
    sleep_take |=> prefetch_pc == $past(core_pc) + 13'd1)
    else $error("prefetch address wrong");
  AST_VECTOR: assert property (@(posedge hclk) disable iff (!hresetn)
    core_resume |=> irq_branch == ($past(wake_by_irq) && $past(global_irq_enable)))
    else $error("vector decision wrong");
  AST_WAKE_CLEARS_WDOG: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_take |-> wd.clear ##1 !wd.timeout)
    else $error("watchdog not cleared on wake");
  AST_STARTUP_LEN: assert property (@(posedge hclk) disable iff (!hresetn)
    core_resume |-> start_seen == (start_xtal ? 11'(XTAL_START_CYC) : 11'(RC_START_CYC)))
    else $error("start-up interval wrong");
  AST_INSTR_CYCLE: assert property (@(posedge hclk) disable iff (!hresetn)
    instr_strobe |=> !instr_strobe [*3])
    else $error("instruction cycle not four periods");
endmodule // sleep_wake_controller

// ===== verilog/swc_cfg.svh
`ifndef SWC_CFG_SVH
`define SWC_CFG_SVH

// register indices; byte address is four times the index
`define SWC_OPTION_IDX 16'h0081
`define SWC_CONFIG_IDX 16'h2007
`define SWC_STATUS_IDX 16'h0003

// timer option field positions
`define OPT_PRESCALER_ASSIGN_BIT 3
`define OPT_RATE_LSB 0
`define OPTION_RESET 8'hff

// device config word field positions
`define CFG_MASTER_CLEAR_EN_BIT 5
`define CFG_WDOG_EN_BIT 3
`define CFG_OSC_SEL_LSB 0
`define OSC_XTAL_MAX 3'd2

// status register bit positions
`define STAT_TIMEOUT_BIT 0
`define STAT_POWER_DOWN_BIT 1
`define STAT_ASLEEP_BIT 2
`define STAT_WAKE_PEND_BIT 3
`define STAT_STARTUP_BIT 4

// timing
`define OSC_PERIOD_NS 25
`define INSTR_TOSC 4
`define XTAL_START_TOSC 1024
`define RC_START_NS 1000
`define WDOG_BASE_US 18000
`define WDOG_TICK_US 1
`define IRQ_VECTOR 13'h0004

`endif

// ===== verilog/swc_pkg.sv
package swc_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_START, ST_RESUME} pwr_state_e;
  typedef logic [12:0] prog_addr_t;
endpackage

// ===== verilog/sync2.sv
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // asynchronous in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // sync2

// ===== verilog/wdog_if.sv
`timescale 1ns/10ps
interface wdog_if;
  logic clear;
  logic enable;
  logic ps_assign;
  logic [2:0] ps_rate;
  logic tick;
  logic timeout;
  modport ctl (output clear, enable, ps_assign, ps_rate, tick, input timeout);
  modport wdog (input clear, enable, ps_assign, ps_rate, tick, output timeout);
endinterface

// ===== verilog/wdog_timer.sv
`timescale 1ns/10ps
module wdog_timer #(
  parameter int BASE_TICKS = 18000
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control from the sequencer
  wdog_if.wdog w
);
  logic [6:0] presc;
  logic [14:0] base;
  logic presc_done;

  // prescaler passes one tick in 2**rate, 1:1 up to 1:128
  assign presc_done = !w.ps_assign || (presc == 7'((1 << w.ps_rate) - 1));

  // clear zeroes the counter, and the prescaler only while it is assigned
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc <= '0;
      base <= '0;
      w.timeout <= 1'b0;
    end else begin
      w.timeout <= 1'b0;
      if (w.clear) begin
        base <= '0;
        if (w.ps_assign) begin
          presc <= '0;
        end
      end else if (w.enable && w.tick) begin
        presc <= presc_done ? 7'd0 : presc + 7'd1;
        if (presc_done) begin
          if (base == 15'(BASE_TICKS - 1)) begin
            base <= '0;
            w.timeout <= 1'b1;
          end else begin
            base <= base + 15'd1;
          end
        end
      end
    end
  end

  AST_WDOG_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn) w.clear |=> !w.timeout && base == 15'd0)
    else $error("watchdog not cleared");
endmodule // wdog_timer
